// File: hw/stw_consts.svh
// offsets, field positions, reset values and timing figures of the supervisor watchdog
`ifndef STW_CONSTS_SVH
`define STW_CONSTS_SVH

`define STW_CLK_PERIOD_NS   50
`define STW_BASE_TIME_US    1000
`define STW_DELAY_TIME_US   2000
`define STW_BASE_CYCLES     (`STW_BASE_TIME_US * 1000 / `STW_CLK_PERIOD_NS)
`define STW_DELAY_CYCLES    (`STW_DELAY_TIME_US * 1000 / `STW_CLK_PERIOD_NS)

`define STW_OFS_CTRL        8'h00
`define STW_OFS_BASE        8'h04
`define STW_OFS_DELAY       8'h08
`define STW_OFS_STATUS      8'h0c
`define STW_OFS_MASK        8'h10
`define STW_OFS_LIVE        8'h14

`define STW_CTRL_SEPARATE   0
`define STW_CTRL_LATCHED    1
`define STW_CTRL_RESET      2'h1

`define STW_EVT_WD_ERROR    0
`define STW_EVT_MANUAL      1
`define STW_EVT_UNDERVOLT   2
`define STW_EVT_WIDTH       3

`define STW_SHIFT_SEL0      4'h0
`define STW_SHIFT_SEL1      4'h2
`define STW_SHIFT_SEL2      4'h4
`define STW_SHIFT_SEL3      4'h8

`define STW_SYNC_WIDTH      6
`define STW_SYNC_RESET      6'h01

`endif

// File: hw/stw_pkg.sv
// types of the supervisor watchdog
package stw_pkg;

  typedef logic [1:0] stw_htrans_t;

  typedef enum logic [2:0]
  {
    STW_RESET,
    STW_RST_DELAY,
    STW_RUN,
    STW_WD_FAULT,
    STW_WD_RESET
  } stw_state_t;

endpackage

// File: hw/stw_sync.sv
// two-flop synchronisers for the asynchronous pins
`timescale 1ns/1ps
`default_nettype none

module stw_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      logic meta;
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          meta        <= RESET_VAL[i];
          sync_out[i] <= RESET_VAL[i];
        end
        else
        begin
          meta        <= async_in[i];
          sync_out[i] <= meta;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// File: hw/stw_top.sv
// reset supervisor with timeout watchdog and AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "stw_consts.svh"

module stw_top #(
  parameter logic [23:0] BASE_CYCLES  = 24'(`STW_BASE_CYCLES),
  parameter logic [23:0] DELAY_CYCLES = 24'(`STW_DELAY_CYCLES)
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire stw_pkg::stw_htrans_t htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output var  logic                hreadyout,
  output var  logic                hresp,
  output var  logic [31:0]         hrdata,
  input  wire logic                manual_reset_n,
  input  wire logic                undervoltage_threshold,
  input  wire logic                watchdog_kick_in,
  input  wire logic                watchdog_enable_pin,
  input  wire logic                timeout_select_0,
  input  wire logic                timeout_select_1,
  output var  logic                reset_out_n,
  output var  logic                watchdog_fault_out_n,
  output var  logic                irq
);
  import stw_pkg::*;

  // pin synchronisers
  logic [`STW_SYNC_WIDTH-1:0] pins_s;
  logic                       mr_s;
  logic                       uv_s;
  logic                       kick_s;
  logic                       en_s;
  logic [1:0]                 sel_s;
  logic                       kick_prev;
  logic                       kick_fall;

  stw_sync #(
    .WIDTH     (`STW_SYNC_WIDTH),
    .RESET_VAL (`STW_SYNC_RESET)
  ) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({timeout_select_1, timeout_select_0, watchdog_enable_pin,
                watchdog_kick_in, undervoltage_threshold, manual_reset_n}),
    .sync_out (pins_s)
  );

  assign mr_s      = pins_s[0];
  assign uv_s      = pins_s[1];
  assign kick_s    = pins_s[2];
  assign en_s      = pins_s[3];
  assign sel_s     = pins_s[5:4];
  assign kick_fall = kick_prev & ~kick_s;

  // registers
  logic [1:0]               ctrl;
  logic [23:0]              base;
  logic [23:0]              delay;
  logic [`STW_EVT_WIDTH-1:0] status;
  logic [`STW_EVT_WIDTH-1:0] mask;

  // bus data phase
  logic       pend;
  logic       pend_write;
  logic [7:0] pend_addr;
  logic       take;
  logic       wr_now;
  logic       wr_ctrl;
  logic       wr_base;
  logic       wr_delay;
  logic       wr_status;
  logic       wr_mask;
  logic [31:0] rdata;

  assign take      = hsel & hready & htrans[1];
  assign wr_now    = pend & ~hreadyout & pend_write;
  assign wr_ctrl   = wr_now & (pend_addr == `STW_OFS_CTRL);
  assign wr_base   = wr_now & (pend_addr == `STW_OFS_BASE);
  assign wr_delay  = wr_now & (pend_addr == `STW_OFS_DELAY);
  assign wr_status = wr_now & (pend_addr == `STW_OFS_STATUS);
  assign wr_mask   = wr_now & (pend_addr == `STW_OFS_MASK);

  // watchdog state
  stw_state_t  state;
  stw_state_t  next_state;
  logic [31:0] wd_cnt;
  logic [31:0] next_wd_cnt;
  logic [31:0] dly_cnt;
  logic [31:0] next_dly_cnt;
  logic [31:0] wd_limit;
  logic [3:0]  wd_shift;
  logic        cause;
  logic        separate;
  logic        latched;
  logic        wd_timeout;
  logic        dly_done;
  logic        reset_state;
  logic [`STW_EVT_WIDTH-1:0] evt_set;
  logic [`STW_EVT_WIDTH-1:0] next_status;

  assign separate = ctrl[`STW_CTRL_SEPARATE];
  assign latched  = ctrl[`STW_CTRL_LATCHED];
  assign cause    = ~mr_s | uv_s;

  // timeout multiplier from select pins
  assign wd_shift = (sel_s == 2'h0) ? `STW_SHIFT_SEL0 :
                    (sel_s == 2'h1) ? `STW_SHIFT_SEL1 :
                    (sel_s == 2'h2) ? `STW_SHIFT_SEL2 : `STW_SHIFT_SEL3;
  assign wd_limit = {8'h00, base} << wd_shift;

  // only counted while running and enabled
  assign wd_timeout = (state == STW_RUN) & en_s & ~kick_fall
                      & (wd_cnt >= wd_limit - 32'h1);
  assign dly_done   = dly_cnt >= {8'h00, delay} - 32'h1;

  always_comb
  begin
    next_state = state;
    unique case (state)
      STW_RESET:
        if (!cause)
          next_state = latched ? STW_RUN : STW_RST_DELAY;
      STW_RST_DELAY:
        if (cause)
          next_state = STW_RESET;
        else if (dly_done)
          next_state = STW_RUN;
      STW_RUN:
        if (cause)
          next_state = STW_RESET;
        else if (wd_timeout)
          next_state = separate ? STW_WD_FAULT : STW_WD_RESET;
      STW_WD_FAULT, STW_WD_RESET:
        if (cause)
          next_state = STW_RESET;
        else if (latched ? kick_fall : dly_done)
          next_state = STW_RUN;
    endcase
  end

  assign reset_state  = (next_state == STW_RESET) | (next_state == STW_RST_DELAY)
                        | (next_state == STW_WD_RESET);
  // restart on kick, disable, and any stay outside run
  assign next_wd_cnt  = (state != STW_RUN || next_state != STW_RUN || !en_s || kick_fall)
                        ? 32'h0 : wd_cnt + 32'h1;
  assign next_dly_cnt = (next_state != state) ? 32'h0 : dly_cnt + 32'h1;

  assign evt_set[`STW_EVT_WD_ERROR]  = wd_timeout & (next_state != STW_RUN);
  assign evt_set[`STW_EVT_MANUAL]    = ~mr_s;
  assign evt_set[`STW_EVT_UNDERVOLT] = uv_s;
  // set wins over a write-one clear
  assign next_status = (status & ~(wr_status ? hwdata[`STW_EVT_WIDTH-1:0] : '0)) | evt_set;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state                <= STW_RST_DELAY;
      wd_cnt               <= 32'h0;
      dly_cnt              <= 32'h0;
      kick_prev            <= 1'b0;
      reset_out_n          <= 1'b0;
      watchdog_fault_out_n <= 1'b1;
    end
    else
    begin
      state                <= next_state;
      wd_cnt               <= next_wd_cnt;
      dly_cnt              <= next_dly_cnt;
      kick_prev            <= kick_s;
      reset_out_n          <= ~reset_state;
      watchdog_fault_out_n <= next_state != STW_WD_FAULT;
    end
  end

  // register file
  assign rdata = (pend_addr == `STW_OFS_CTRL)   ? {30'h0, ctrl} :
                 (pend_addr == `STW_OFS_BASE)   ? {8'h00, base} :
                 (pend_addr == `STW_OFS_DELAY)  ? {8'h00, delay} :
                 (pend_addr == `STW_OFS_STATUS) ? {29'h0, status} :
                 (pend_addr == `STW_OFS_MASK)   ? {29'h0, mask} :
                 (pend_addr == `STW_OFS_LIVE)   ? {22'h0, en_s, sel_s, watchdog_fault_out_n,
                                                   reset_out_n, 2'h0, state} :
                 32'h0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl   <= `STW_CTRL_RESET;
      base   <= BASE_CYCLES;
      delay  <= DELAY_CYCLES;
      status <= '0;
      mask   <= '0;
      irq    <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= hwdata[1:0];
      if (wr_base)
        base <= hwdata[23:0];
      if (wr_delay)
        delay <= hwdata[23:0];
      if (wr_mask)
        mask <= hwdata[`STW_EVT_WIDTH-1:0];
      status <= next_status;
      irq    <= |(next_status & (wr_mask ? hwdata[`STW_EVT_WIDTH-1:0] : mask));
    end
  end

  // one wait state per transfer so read data comes from a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend       <= 1'b0;
      pend_write <= 1'b0;
      pend_addr  <= 8'h00;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      hrdata     <= 32'h0;
    end
    else if (pend && !hreadyout)
    begin
      hreadyout <= 1'b1;
      pend      <= 1'b0;
      hrdata    <= pend_write ? 32'h0 : rdata;
    end
    else if (take)
    begin
      pend       <= 1'b1;
      pend_write <= hwrite;
      pend_addr  <= {haddr[7:2], 2'h0};
      hreadyout  <= 1'b0;
    end
  end

  // checks
  logic [31:0] flt_len;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flt_len <= 32'h0;
    else
      flt_len <= watchdog_fault_out_n ? 32'h0 : flt_len + 32'h1;
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_fault_entry;
    (state == STW_RUN) && wd_timeout && !cause;
  endsequence

  sequence s_fault_end;
    (state == STW_WD_FAULT) && !latched && !cause && dly_done;
  endsequence

  a_manual_reset: assert property (!mr_s |=> !reset_out_n)
    else $error("manual reset did not assert reset output");
  a_undervolt_reset: assert property (uv_s |=> !reset_out_n)
    else $error("undervoltage did not assert reset output");
  a_disabled_quiet: assert property (!en_s |-> !wd_timeout ##1 wd_cnt == 32'h0)
    else $error("watchdog active while disabled");
  a_timeout_error: assert property (s_fault_entry |=> state inside {STW_WD_FAULT, STW_WD_RESET})
    else $error("missed kick gave no watchdog error");
  a_error_to_reset: assert property ((s_fault_entry and !separate) |=> !reset_out_n)
    else $error("watchdog error did not assert reset output");
  a_fault_gated: assert property (!watchdog_fault_out_n |-> reset_out_n)
    else $error("fault output asserted during reset");
  a_fault_length: assert property (!watchdog_fault_out_n && !latched |-> flt_len < {8'h00, delay})
    else $error("fault output longer than reset delay");
  a_fault_release: assert property (s_fault_end |=> watchdog_fault_out_n)
    else $error("fault output not released after reset delay");
  a_reset_suspends: assert property (!reset_out_n |-> watchdog_fault_out_n && wd_cnt == 32'h0)
    else $error("watchdog active during reset");
  a_limit_decode: assert property (sel_s == 2'h3 |-> wd_limit == {base, 8'h00})
    else $error("256x timeout decode wrong");
  a_limit_base: assert property (sel_s == 2'h0 |-> wd_limit == {8'h00, base})
    else $error("1x timeout decode wrong");
  a_latched_hold: assert property ((state == STW_WD_FAULT) && latched && !kick_fall && !cause
                                   |=> !watchdog_fault_out_n)
    else $error("latched fault output released early");
  a_kick_restart: assert property ((state == STW_RUN) && kick_fall |=> wd_cnt == 32'h0)
    else $error("kick edge did not restart counter");
  a_release_restart: assert property ($rose(reset_out_n) |-> wd_cnt == 32'h0)
    else $error("counter not zero at reset release");

endmodule

`default_nettype wire

// File: test/stw_host_model.sv
// host model that kicks the watchdog input with falling edges
`timescale 1ns/1ps
`default_nettype none

module stw_host_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       kick_run,
  input  wire logic [3:0] kick_half,
  output var  logic       watchdog_kick_in
);
  logic [3:0] cnt;

  // toggles every kick_half+1 cycles, so a fall comes well inside the timeout
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt              <= 4'h0;
      watchdog_kick_in <= 1'b1;
    end
    else if (kick_run)
    begin
      cnt <= (cnt >= kick_half) ? 4'h0 : cnt + 4'h1;
      if (cnt >= kick_half)
        watchdog_kick_in <= ~watchdog_kick_in;
    end
  end
endmodule

`default_nettype wire

// File: test/tb_supervisor_timeout_watchdog.sv
// self-checking bench of the supervisor watchdog
`timescale 1ns/1ps
`default_nettype none
`include "stw_consts.svh"

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module tb_supervisor_timeout_watchdog;
  import stw_pkg::*;
  localparam int BASE = 16;
  localparam int DLY  = 8;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, kick_run;
  logic [31:0] haddr, hwdata, hrdata, rd, g_v, e_v;
  stw_htrans_t htrans;
  logic [2:0]  hsize;
  logic        manual_reset_n, undervoltage_threshold, watchdog_kick_in;
  logic        watchdog_enable_pin, timeout_select_0, timeout_select_1;
  logic        reset_out_n, watchdog_fault_out_n;
  logic [3:0]  kick_half;
  logic [31:0] got_q[$];
  logic [31:0] exp_q[$];
  int          mismatches, cmp_count, seed, lead, dur, lim;
  event        noted;

  stw_top #(.BASE_CYCLES(24'h10), .DELAY_CYCLES(24'h8)) i_stw_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .manual_reset_n(manual_reset_n), .undervoltage_threshold(undervoltage_threshold),
    .watchdog_kick_in(watchdog_kick_in), .watchdog_enable_pin(watchdog_enable_pin),
    .timeout_select_0(timeout_select_0), .timeout_select_1(timeout_select_1),
    .reset_out_n(reset_out_n), .watchdog_fault_out_n(watchdog_fault_out_n), .irq(irq));

  stw_host_model i_stw_host_model (
    .hclk(hclk), .hresetn(hresetn), .kick_run(kick_run), .kick_half(kick_half),
    .watchdog_kick_in(watchdog_kick_in));

  initial hclk = 1'b0;
  always #25 hclk = ~hclk;

  task automatic note(input logic [31:0] g, input logic [31:0] e);
    got_q.push_back(g);
    exp_q.push_back(e);
    -> noted;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // one single word transfer; waits on hready in both phases
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    rd = hrdata;
  endtask

  // cycles until the fault output falls, then cycles it stays low
  task automatic fault_len();
    lead = 0;
    dur  = 0;
    while (watchdog_fault_out_n !== 1'b0)
    begin
      @(posedge hclk);
      lead++;
    end
    while (watchdog_fault_out_n === 1'b0)
    begin
      @(posedge hclk);
      dur++;
    end
  endtask

  task automatic report_and_stop();
    #1;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always
  begin
    @(noted);
    while (exp_q.size() > 0)
    begin
      g_v = got_q.pop_front();
      e_v = exp_q.pop_front();
      `CHK(g_v, e_v)
    end
  end

  initial
  begin
    cyc(30000);
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    seed = 24755;
    {hresetn, hsel, htrans, haddr, hwrite, hwdata, kick_run} = '0;
    hsize = 3'h2;
    kick_half = 4'h2;
    {manual_reset_n, undervoltage_threshold, watchdog_enable_pin} = 3'b100;
    {timeout_select_1, timeout_select_0} = 2'h0;
    cyc(2);
    hresetn <= 1'b1;
    note(reset_out_n, 1'b0);
    while (reset_out_n !== 1'b1)
      @(posedge hclk);
    note(watchdog_fault_out_n, 1'b1);
    ahb(0, `STW_OFS_CTRL, 0);
    note(rd, 32'h1);
    ahb(0, `STW_OFS_BASE, 0);
    note(rd, BASE);
    ahb(0, `STW_OFS_DELAY, 0);
    note(rd, DLY);
    ahb(1, 8'h20, $random(seed));
    ahb(0, 8'h20, 0);
    note(rd, 32'h0);
    note(hresp, 1'b0);
    ahb(0, `STW_OFS_LIVE, 0);
    note(rd, 32'h62);
    $display("power-on and registers done");
    for (int i = 0; i < 2; i++)
    begin
      watchdog_enable_pin <= 1'b1;
      manual_reset_n <= (i != 0);
      undervoltage_threshold <= (i == 1);
      cyc(3 * BASE);
      note(reset_out_n, 1'b0);
      note(watchdog_fault_out_n, 1'b1);
      ahb(0, `STW_OFS_STATUS, 0);
      note(rd[2:0], (i == 0) ? 3'h2 : 3'h4);
      manual_reset_n <= 1'b1;
      undervoltage_threshold <= 1'b0;
      while (reset_out_n !== 1'b1)
        @(posedge hclk);
      fault_len();
      watchdog_enable_pin <= 1'b0;
      note(lead >= BASE - 3 && lead <= BASE + 3, 1'b1);
      note(dur, DLY);
      note(reset_out_n, 1'b1);
      ahb(1, `STW_OFS_STATUS, 32'h7);
      $display("cause %0d done", i);
    end
    cyc(5 * BASE);
    ahb(0, `STW_OFS_STATUS, 0);
    note(rd[0], 1'b0);
    ahb(1, `STW_OFS_MASK, 32'h1);
    for (int s = 0; s < 4; s++)
    begin
      lim = BASE << ((s == 3) ? 8 : 2 * s);
      {timeout_select_1, timeout_select_0} <= 2'(s);
      kick_half <= 4'($random(seed)) & 4'h3;
      kick_run <= 1'b1;
      watchdog_enable_pin <= 1'b1;
      cyc(lim + BASE);
      ahb(0, `STW_OFS_STATUS, 0);
      note(rd[0], 1'b0);
      @(negedge watchdog_kick_in);
      @(posedge hclk);
      kick_run <= 1'b0;
      fault_len();
      watchdog_enable_pin <= 1'b0;
      note(lead >= lim - 2 && lead <= lim + 4, 1'b1);
      note(irq, 1'b1);
      ahb(1, `STW_OFS_STATUS, 32'h1);
      cyc(2);
      note(irq, 1'b0);
      $display("select %0d done", s);
    end
    ahb(1, `STW_OFS_MASK, 32'h0);
    ahb(1, `STW_OFS_CTRL, 32'h0);
    {timeout_select_1, timeout_select_0} <= 2'h0;
    watchdog_enable_pin <= 1'b1;
    while (reset_out_n !== 1'b0)
      @(posedge hclk);
    dur = 0;
    while (reset_out_n === 1'b0)
    begin
      @(posedge hclk);
      dur++;
    end
    watchdog_enable_pin <= 1'b0;
    note(dur, DLY);
    note(watchdog_fault_out_n, 1'b1);
    note(irq, 1'b0);
    $display("shared reset variant done");
    ahb(1, `STW_OFS_CTRL, 32'h3);
    watchdog_enable_pin <= 1'b1;
    while (watchdog_fault_out_n !== 1'b0)
      @(posedge hclk);
    cyc(3 * DLY);
    note(watchdog_fault_out_n, 1'b0);
    kick_half <= 4'h2;
    kick_run <= 1'b1;
    cyc(20);
    note(watchdog_fault_out_n, 1'b1);
    watchdog_enable_pin <= 1'b0;
    $display("latched variant done");
    report_and_stop();
  end
endmodule

`default_nettype wire
